// File: logic/tbx_pkg.sv
// Constants, types and helper functions shared by the bus exerciser blocks.
// Assumes a single 125 MHz clock domain and a plain register port.
package tbx_pkg;

    // Register offsets (byte addresses on the register port).
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_START  = 8'h04;
    localparam logic [7:0] OFF_END    = 8'h08;
    localparam logic [7:0] OFF_DATA   = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RDATA  = 8'h14;
    localparam logic [7:0] OFF_CRCREF = 8'h18;
    localparam logic [7:0] OFF_RCHAR  = 8'h1C;
    localparam logic [7:0] OFF_CYCLES = 8'h20;
    localparam logic [7:0] OFF_CRCVAL = 8'h24;

    // Control register fields.
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_WORD_BIT = 8;
    localparam int CTRL_MSS_LSB  = 9;
    localparam int CTRL_GO_BIT   = 31;

    // Values after reset.
    localparam logic [7:0]  RCHAR_RST  = 8'h1A;
    localparam logic [15:0] CRCREF_RST = 16'h0000;

    // Special function command codes.
    localparam logic [5:0] FC_TOGGLE = 6'h04;
    localparam logic [5:0] FC_PEEK   = 6'h05;
    localparam logic [5:0] FC_POKE   = 6'h06;
    localparam logic [5:0] FC_ALT    = 6'h07;
    localparam logic [5:0] FC_ROT    = 6'h08;
    localparam logic [5:0] FC_WRRD   = 6'h09;
    localparam logic [5:0] FC_INC    = 6'h0B;
    localparam logic [5:0] FC_RANGE  = 6'h0C;
    localparam logic [5:0] FC_CRC    = 6'h0D;
    localparam logic [5:0] FC_IO_OFS = 6'h14;

    // Firmware checksum polynomial and seed.
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    typedef enum logic [2:0] {
        TBX_PM_POKE,
        TBX_PM_TOGGLE,
        TBX_PM_ALT,
        TBX_PM_ROT,
        TBX_PM_INC
    } tbx_pmode_t;

    function automatic logic [15:0] width_mask(input logic word);
        return word ? 16'hFFFF : 16'h00FF;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] b);
        logic [15:0] c;
        c = c_in ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) begin
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// File: logic/tbx_sub_if.sv
// Carrier between the exerciser core and its pattern and checksum engines.
// Assumes all three parties share the one system clock.
`timescale 1ns/1ps
interface tbx_sub_if;
    tbx_pkg::tbx_pmode_t pmode;
    logic                word;
    logic [15:0]         seed;
    logic                load;
    logic                step;
    logic [15:0]         value;
    logic                crc_start;
    logic                crc_busy;
    logic                crc_done;
    logic [15:0]         crc_val;

    modport ctl (output pmode, word, seed, load, step, crc_start,
                 input  value, crc_busy, crc_done, crc_val);
    modport pat (input  pmode, word, seed, load, step, output value);
    modport crc (input  crc_start, output crc_busy, crc_done, crc_val);
endinterface

// File: logic/tbx_pattern.sv
// Write data pattern generator for the looping exerciser functions.
// Assumes load and step are single-cycle strobes from the core.
`timescale 1ns/1ps
module tbx_pattern (
    input wire logic mclk,
    input wire logic rst_b,
    tbx_sub_if.pat   sif
);
    typedef struct packed {
        logic [15:0] user;
        logic [15:0] out;
        logic        phase;
    } tbx_pat_st_t;

    tbx_pat_st_t s_r;
    tbx_pat_st_t s_nxt;
    logic [15:0] m;

    always_comb begin
        s_nxt = s_r;
        m = tbx_pkg::width_mask(sif.word);
        if (sif.load) begin
            s_nxt.user  = sif.seed & m;
            s_nxt.phase = 1'b0;
            s_nxt.out   = (sif.pmode == tbx_pkg::TBX_PM_TOGGLE) ? 16'h0000 : (sif.seed & m);
        end else if (sif.step) begin
            s_nxt.phase = ~s_r.phase;
            unique case (sif.pmode)
                tbx_pkg::TBX_PM_TOGGLE: s_nxt.out = s_nxt.phase ? s_r.user : 16'h0000;
                tbx_pkg::TBX_PM_ALT:    s_nxt.out = s_nxt.phase ? (~s_r.user & m) : s_r.user;
                tbx_pkg::TBX_PM_ROT:    s_nxt.out = sif.word ? {s_r.out[14:0], s_r.out[15]}
                                                             : {8'h00, s_r.out[6:0], s_r.out[7]};
                tbx_pkg::TBX_PM_INC:    s_nxt.out = (s_r.out + 16'h0001) & m;
                tbx_pkg::TBX_PM_POKE:   s_nxt.out = s_r.user;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.value = s_r.out;
endmodule

// File: logic/tbx_crc.sv
// Single-pass checksum engine over the internal firmware image.
// Assumes crc_start is a one-cycle strobe given only while idle.
`timescale 1ns/1ps
module tbx_crc #(
    parameter int PROM_BYTES = 256
) (
    input wire logic mclk,
    input wire logic rst_b,
    tbx_sub_if.crc   sif
);
    localparam int IW = $clog2(PROM_BYTES);
    localparam logic [IW-1:0] LAST = IW'(PROM_BYTES - 1);

    typedef struct packed {
        logic          busy;
        logic          done;
        logic [IW-1:0] idx;
        logic [15:0]   crc;
    } tbx_crc_st_t;

    tbx_crc_st_t s_r;
    tbx_crc_st_t s_nxt;
    logic [7:0]  prom [PROM_BYTES];

    // Stand-in firmware image; a real build replaces this table.
    always_comb begin
        for (int i = 0; i < PROM_BYTES; i++) begin
            prom[i] = 8'((i * 37 + 5) % 256);
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.busy && sif.crc_start) begin
            s_nxt.busy = 1'b1;
            s_nxt.idx  = '0;
            s_nxt.crc  = tbx_pkg::CRC_INIT;
        end else if (s_r.busy) begin
            s_nxt.crc = tbx_pkg::crc_byte(s_r.crc, prom[s_r.idx]);
            if (s_r.idx == LAST) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.idx = s_r.idx + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.crc_busy = s_r.busy;
    assign sif.crc_done = s_r.done;
    assign sif.crc_val  = s_r.crc;
endmodule

// File: logic/tbx_top.sv
// Target bus exerciser: looping read/write cycles and firmware checksum test.
// Assumes emu_paused, rx_char/rx_valid and the target bus all run on mclk.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module tbx_top #(
    parameter int AW         = 20,
    parameter int PROM_BYTES = 256
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    input  wire logic          emu_paused,
    input  wire logic [7:0]    rx_char,
    input  wire logic          rx_valid,
    output logic               tgt_req,
    output logic               tgt_we,
    output logic               tgt_io,
    output logic      [2:0]    tgt_mss,
    output logic      [AW-1:0] tgt_addr,
    output logic               tgt_word,
    output logic      [15:0]   tgt_wdata,
    input  wire logic          tgt_ack,
    input  wire logic [15:0]   tgt_rdata,
    output logic               exer_busy,
    output logic               crc_error
);
    typedef enum logic [1:0] {
        TBX_IDLE,
        TBX_BUS,
        TBX_CHK
    } tbx_state_t;

    typedef struct packed {
        tbx_state_t  st;
        logic [5:0]  code;
        logic        word;
        logic [2:0]  mss;
        logic [AW-1:0] astart;
        logic [AW-1:0] aend;
        logic [15:0] data;
        logic [15:0] crc_ref;
        logic [7:0]  rchar;
        logic [5:0]  base;
        logic        io;
        logic [AW-1:0] addr;
        logic        we;
        logic        req;
        logic        stop;
        logic [15:0] rdata_last;
        logic [31:0] cycles;
        logic        crc_done;
        logic        crc_err;
        logic        rejected;
        logic [31:0] rd_data;
        logic        busy;
    } tbx_top_st_t;

    tbx_top_st_t s_r;
    tbx_top_st_t s_nxt;

    tbx_sub_if sif ();

    tbx_pattern u_pattern (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sif   (sif)
    );

    tbx_crc #(
        .PROM_BYTES (PROM_BYTES)
    ) u_crc (
        .mclk  (mclk),
        .rst_b (rst_b),
        .sif   (sif)
    );

    // Strips the I/O offset so memory and I/O codes share one decode.
    function automatic logic [5:0] base_of(input logic [5:0] code);
        return (code >= tbx_pkg::FC_IO_OFS) ? 6'(code - tbx_pkg::FC_IO_OFS) : code;
    endfunction

    function automatic logic code_ok(input logic [5:0] code);
        logic [5:0] b;
        b = base_of(code);
        if (code == tbx_pkg::FC_CRC) begin
            return 1'b1;
        end
        return (b == tbx_pkg::FC_TOGGLE) || (b == tbx_pkg::FC_PEEK) || (b == tbx_pkg::FC_POKE)
            || (b == tbx_pkg::FC_ALT) || (b == tbx_pkg::FC_ROT) || (b == tbx_pkg::FC_WRRD)
            || (b == tbx_pkg::FC_INC) || (b == tbx_pkg::FC_RANGE);
    endfunction

    logic go;
    logic char_hit;
    logic acked;

    always_comb begin
        s_nxt = s_r;
        sif.load      = 1'b0;
        sif.step      = 1'b0;
        sif.crc_start = 1'b0;
        sif.seed      = s_r.data;
        go       = reg_wr && (reg_addr == tbx_pkg::OFF_CTRL) && reg_wdata[tbx_pkg::CTRL_GO_BIT];
        char_hit = rx_valid && (rx_char == s_r.rchar);
        acked    = (s_r.st == TBX_BUS) && s_r.req && tgt_ack;

        // Setup registers are frozen while a function runs.
        if (reg_wr && (s_r.st == TBX_IDLE)) begin
            unique case (reg_addr)
                tbx_pkg::OFF_CTRL: begin
                    s_nxt.code = reg_wdata[tbx_pkg::CTRL_CODE_LSB +: 6];
                    s_nxt.word = reg_wdata[tbx_pkg::CTRL_WORD_BIT];
                    s_nxt.mss  = reg_wdata[tbx_pkg::CTRL_MSS_LSB +: 3];
                end
                tbx_pkg::OFF_START:  s_nxt.astart  = reg_wdata[AW-1:0];
                tbx_pkg::OFF_END:    s_nxt.aend    = reg_wdata[AW-1:0];
                tbx_pkg::OFF_DATA:   s_nxt.data    = reg_wdata[15:0];
                tbx_pkg::OFF_CRCREF: s_nxt.crc_ref = reg_wdata[15:0];
                tbx_pkg::OFF_RCHAR:  s_nxt.rchar   = reg_wdata[7:0];
                default: ;
            endcase
        end
        sif.word = s_nxt.word;

        // Command acceptance.
        if (go) begin
            if ((s_r.st == TBX_IDLE) && emu_paused && code_ok(s_nxt.code)) begin
                s_nxt.rejected = 1'b0;
                s_nxt.crc_done = 1'b0;
                s_nxt.crc_err  = 1'b0;
                s_nxt.stop     = 1'b0;
                s_nxt.cycles   = '0;
                if (s_nxt.code == tbx_pkg::FC_CRC) begin
                    s_nxt.st      = TBX_CHK;
                    sif.crc_start = 1'b1;
                end else begin
                    s_nxt.st   = TBX_BUS;
                    s_nxt.base = base_of(s_nxt.code);
                    s_nxt.io   = s_nxt.code >= tbx_pkg::FC_IO_OFS;
                    s_nxt.addr = s_nxt.astart;
                    s_nxt.we   = (s_nxt.base != tbx_pkg::FC_PEEK)
                              && (s_nxt.base != tbx_pkg::FC_RANGE);
                    s_nxt.req  = 1'b1;
                    sif.seed   = s_nxt.data;
                    sif.load   = 1'b1;
                end
            end else begin
                s_nxt.rejected = 1'b1;
            end
        end

        // Looping bus cycles.
        if (s_r.st == TBX_BUS) begin
            if (acked) begin
                s_nxt.cycles = s_r.cycles + 32'h0000_0001;
                if (!s_r.we) begin
                    s_nxt.rdata_last = tgt_rdata & tbx_pkg::width_mask(s_r.word);
                end
                sif.step = s_r.we;
                if (s_r.stop || char_hit) begin
                    s_nxt.st   = TBX_IDLE;
                    s_nxt.req  = 1'b0;
                    s_nxt.stop = 1'b0;
                end else if (s_r.base == tbx_pkg::FC_RANGE) begin
                    s_nxt.addr = (s_r.addr == s_r.aend) ? s_r.astart : s_r.addr + 1'b1;
                end else if (s_r.base == tbx_pkg::FC_WRRD) begin
                    s_nxt.we = ~s_r.we;
                end
            end else if (char_hit) begin
                s_nxt.stop = 1'b1;
            end
        end

        // Checksum self-test, a single pass.
        if ((s_r.st == TBX_CHK) && sif.crc_done) begin
            s_nxt.st       = TBX_IDLE;
            s_nxt.crc_done = 1'b1;
            s_nxt.crc_err  = sif.crc_val != s_r.crc_ref;
        end

        // Busy is kept as its own flip-flop so the output needs no decode.
        s_nxt.busy = s_nxt.st != TBX_IDLE;

        // Pattern selection follows the base function code.
        unique case (s_nxt.base)
            tbx_pkg::FC_TOGGLE: sif.pmode = tbx_pkg::TBX_PM_TOGGLE;
            tbx_pkg::FC_ALT:    sif.pmode = tbx_pkg::TBX_PM_ALT;
            tbx_pkg::FC_ROT:    sif.pmode = tbx_pkg::TBX_PM_ROT;
            tbx_pkg::FC_INC:    sif.pmode = tbx_pkg::TBX_PM_INC;
            default:            sif.pmode = tbx_pkg::TBX_PM_POKE;
        endcase

        // Read data stands only in the cycle after the strobe.
        s_nxt.rd_data = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                tbx_pkg::OFF_CTRL:   s_nxt.rd_data = {20'h0_0000, s_r.mss, s_r.word, 2'b00, s_r.code};
                tbx_pkg::OFF_START:  s_nxt.rd_data = 32'(s_r.astart);
                tbx_pkg::OFF_END:    s_nxt.rd_data = 32'(s_r.aend);
                tbx_pkg::OFF_DATA:   s_nxt.rd_data = {16'h0000, s_r.data};
                tbx_pkg::OFF_STATUS: s_nxt.rd_data = {27'h000_0000, s_r.stop, s_r.rejected,
                                                      s_r.crc_err, s_r.crc_done, s_r.st != TBX_IDLE};
                tbx_pkg::OFF_RDATA:  s_nxt.rd_data = {16'h0000, s_r.rdata_last};
                tbx_pkg::OFF_CRCREF: s_nxt.rd_data = {16'h0000, s_r.crc_ref};
                tbx_pkg::OFF_RCHAR:  s_nxt.rd_data = {24'h00_0000, s_r.rchar};
                tbx_pkg::OFF_CYCLES: s_nxt.rd_data = s_r.cycles;
                tbx_pkg::OFF_CRCVAL: s_nxt.rd_data = {16'h0000, sif.crc_val};
                default:             s_nxt.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_r         <= '0;
            s_r.st      <= TBX_IDLE;
            s_r.rchar   <= tbx_pkg::RCHAR_RST;
            s_r.crc_ref <= tbx_pkg::CRCREF_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rd_data;
    assign tgt_req   = s_r.req;
    assign tgt_we    = s_r.we;
    assign tgt_io    = s_r.io;
    assign tgt_mss   = s_r.mss;
    assign tgt_addr  = s_r.addr;
    assign tgt_word  = s_r.word;
    assign tgt_wdata = sif.value;
    assign exer_busy = s_r.busy;
    assign crc_error = s_r.crc_err;
endmodule

// File: sim/tbx_top_asserts.sv
// Checker for the exerciser top: bus holding, stop behaviour and pattern limits.
// Assumes one clock domain; bound into every tbx_top instance.
`timescale 1ns/1ps
module tbx_top_chk #(
    parameter int AW = 20
) (
    input wire logic          mclk,
    input wire logic          rst_b,
    input wire logic          emu_paused,
    input wire logic          tgt_req,
    input wire logic          tgt_we,
    input wire logic          tgt_io,
    input wire logic [AW-1:0] tgt_addr,
    input wire logic          tgt_word,
    input wire logic [15:0]   tgt_wdata,
    input wire logic          tgt_ack,
    input wire logic          exer_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_hold;
        tgt_req && !tgt_ack |=> tgt_req && $stable(tgt_addr) && $stable(tgt_we) && $stable(tgt_wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("bus cycle changed before ack");
    property p_paused;
        $rose(exer_busy) |-> $past(emu_paused);
    endproperty
    a_paused: assert property (p_paused) else $error("function started while running");
    property p_byte;
        tgt_req && tgt_we && !tgt_word |-> tgt_wdata[15:8] == 8'h00;
    endproperty
    a_byte: assert property (p_byte) else $error("byte write has upper data bits set");
    property p_wr_same;
        tgt_req && tgt_ack && tgt_we ##1 tgt_req |-> tgt_addr == $past(tgt_addr);
    endproperty
    a_wr_same: assert property (p_wr_same) else $error("write loop moved its address");
    property p_rd_step;
        tgt_req && tgt_ack && !tgt_we ##1 tgt_req && !tgt_we
            |-> tgt_addr == $past(tgt_addr) + 1'b1 || tgt_addr <= $past(tgt_addr);
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read address skipped ahead");
    property p_fell_ack;
        $fell(tgt_req) |-> $past(tgt_ack);
    endproperty
    a_fell_ack: assert property (p_fell_ack) else $error("request dropped without ack");
    property p_busy_drop;
        $fell(exer_busy) |-> !tgt_req;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("idle with a request open");
    property p_space;
        exer_busy && $past(exer_busy) && tgt_req |-> $stable(tgt_io) && $stable(tgt_word);
    endproperty
    a_space: assert property (p_space) else $error("space or width changed mid loop");
endmodule

bind tbx_top tbx_top_chk #(.AW(AW)) u_chk (.mclk, .rst_b, .emu_paused, .tgt_req, .tgt_we, .tgt_io,
    .tgt_addr, .tgt_word, .tgt_wdata, .tgt_ack, .exer_busy);

// File: sim/tbx_tgt_model.sv
// Target memory and I/O bus model: acks each request promptly or after three waits.
// Assumes the exerciser holds a request until it sees ack.
`timescale 1ns/1ps
module tbx_tgt_model (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        slow,
    input wire logic        req,
    input wire logic [7:0]  addr,
    output logic            ack,
    output logic [15:0]     rdata
);
    logic [1:0] wait_r;

    // Data lines flip every cycle outside an ack so stale values never look valid.
    always @(posedge mclk) begin
        if (!rst_b) begin
            ack <= 1'b0;
            wait_r <= 2'h0;
            rdata <= 16'h0000;
        end else if (req && !ack && wait_r == 2'h0) begin
            ack <= 1'b1;
            rdata <= {8'h5A, addr};
            wait_r <= slow ? 2'h3 : 2'h0;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            if (req && !ack) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule

// File: sim/test_target_bus_exerciser.sv
// Self-checking bench: register tasks start each function, a monitor logs bus cycles.
// Assumes the target model and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("BAD at %0t: got %h expected %h", $time, g, e); end end
module test_target_bus_exerciser;
    localparam int AW = 20;
    localparam int PB = 16;
    localparam int LIM = 3000;
    logic          mclk = 1'b0;
    logic          rst_b = 1'b0;
    logic [7:0]    reg_addr = 8'h00;
    logic [31:0]   reg_wdata = 32'h0000_0000;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic [31:0]   reg_rdata;
    logic          emu_paused = 1'b1;
    logic [7:0]    rx_char = 8'h00;
    logic          rx_valid = 1'b0;
    logic          slow = 1'b0;
    logic          tgt_req, tgt_we, tgt_io, tgt_word, tgt_ack, exer_busy, crc_error;
    logic [2:0]    tgt_mss;
    logic [AW-1:0] tgt_addr;
    logic [15:0]   tgt_wdata, tgt_rdata, cref;
    int            failures = 0;
    int            tests_run = 0;
    logic [7:0]    rc = 8'h1A;
    logic [41:0]   log_q[$];
    logic [31:0]   rv;
    logic [5:0]    codes [16] = '{6'h0C, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0B,
                                  6'h20, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F};

    always #4 mclk = ~mclk;

    tbx_top #(.AW(AW), .PROM_BYTES(PB)) uut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .emu_paused, .rx_char, .rx_valid, .tgt_req, .tgt_we, .tgt_io, .tgt_mss, .tgt_addr,
        .tgt_word, .tgt_wdata, .tgt_ack, .tgt_rdata, .exer_busy, .crc_error);
    tbx_tgt_model tgt (.mclk, .rst_b, .slow, .req(tgt_req), .addr(tgt_addr[7:0]), .ack(tgt_ack),
        .rdata(tgt_rdata));

    always @(posedge mclk) begin
        if (tgt_req === 1'b1 && tgt_ack === 1'b1) begin
            log_q.push_back({tgt_we, tgt_io, tgt_word, tgt_io ? 3'h0 : tgt_mss, tgt_addr,
                             tgt_we ? tgt_wdata : 16'h0000});
        end
    end

    task automatic finish_test();
        $display("Checks run %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic to_chk(input int k);
        if (k >= LIM) begin
            failures++;
            $display("BAD at %0t: wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask

    task automatic send(input logic [7:0] c);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // Returns {write, data} of the i-th cycle; data is zero on reads.
    function automatic logic [16:0] exp_cyc(input logic [5:0] b, input int i, input logic [15:0] d,
                                            input logic w);
        logic [15:0] m;
        logic [15:0] v;
        m = w ? 16'hFFFF : 16'h00FF;
        v = d & m;
        case (b)
            tbx_pkg::FC_RANGE, tbx_pkg::FC_PEEK: return 17'h0_0000;
            tbx_pkg::FC_TOGGLE: return {1'b1, i[0] ? v : 16'h0000};
            tbx_pkg::FC_POKE: return {1'b1, v};
            tbx_pkg::FC_ALT: return {1'b1, i[0] ? ~v & m : v};
            tbx_pkg::FC_ROT: begin
                repeat (i) v = w ? {v[14:0], v[15]} : {8'h00, v[6:0], v[7]};
                return {1'b1, v};
            end
            tbx_pkg::FC_WRRD: return i[0] ? 17'h0_0000 : {1'b1, v};
            default: return {1'b1, (d + i[15:0]) & m};
        endcase
    endfunction

    function automatic logic [15:0] crc_ref();
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < PB; i++) begin
            c = c ^ {8'(i * 37 + 5), 8'h00};
            for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        return c;
    endfunction

    task automatic run(input logic [5:0] code, input logic word, input logic [15:0] d, input int n);
        logic          io;
        logic [5:0]    b;
        logic [16:0]   e;
        logic [AW-1:0] ad;
        int            k;
        io = code >= 6'h18;
        b = io ? code - tbx_pkg::FC_IO_OFS : code;
        wr(tbx_pkg::OFF_START, (b == tbx_pkg::FC_RANGE) ? 32'h0000_0002 : 32'h0000_0009);
        wr(tbx_pkg::OFF_END, (b == tbx_pkg::FC_RANGE) ? 32'h0000_0004 : 32'h0000_0009);
        wr(tbx_pkg::OFF_DATA, {16'h0000, d});
        log_q.delete();
        wr(tbx_pkg::OFF_CTRL, {1'b1, 19'h0_0000, 3'h5, word, 2'h0, code});
        for (k = 0; k < LIM && log_q.size() < n; k++) @(posedge mclk);
        to_chk(k);
        send((rc == 8'h1A) ? 8'h03 : 8'h1A);
        `CHK(exer_busy, 1'b1)
        rx_char <= rc;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        for (k = 0; k < LIM && exer_busy !== 1'b0; k++) @(posedge mclk);
        to_chk(k);
        k = log_q.size();
        repeat (3) @(posedge mclk);
        `CHK(log_q.size(), k)
        for (int i = 0; i < n; i++) begin
            e = exp_cyc(b, i, d, word);
            ad = (b == tbx_pkg::FC_RANGE) ? 20'h0_0002 + 20'(i % 3) : 20'h0_0009;
            `CHK(log_q[i], {e[16], io, word, io ? 3'h0 : 3'h5, ad, e[15:0]})
        end
        $display("Test code %h done", code);
    endtask

    task automatic run_crc();
        int k;
        wr(tbx_pkg::OFF_CTRL, 32'h8000_000D);
        for (k = 0; k < LIM && exer_busy !== 1'b0; k++) @(posedge mclk);
        to_chk(k);
        repeat (4) @(posedge mclk);
        `CHK(exer_busy, 1'b0)
        `CHK(tgt_req, 1'b0)
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(tbx_pkg::OFF_RCHAR, rv);
        `CHK(rv, 32'h0000_001A)
        rd(tbx_pkg::OFF_CRCREF, rv);
        `CHK(rv, 32'h0000_0000)
        rd(8'hFC, rv);
        `CHK(rv, 32'h0000_0000)
        $display("Test reset values done");
        emu_paused <= 1'b0;
        wr(tbx_pkg::OFF_CTRL, 32'h8000_0005);
        repeat (3) @(posedge mclk);
        `CHK(exer_busy, 1'b0)
        `CHK(tgt_req, 1'b0)
        rd(tbx_pkg::OFF_STATUS, rv);
        `CHK(rv[3], 1'b1)
        emu_paused <= 1'b1;
        $display("Test refusal while running done");
        for (int j = 0; j < 16; j++) begin
            if (j == 8) begin
                wr(tbx_pkg::OFF_RCHAR, 32'h0000_0003);
                rc = 8'h03;
            end
            slow <= j[1];
            run(codes[j], j[0], 16'hC1A5, 8);
        end
        cref = crc_ref();
        wr(tbx_pkg::OFF_CRCREF, {16'h0000, ~cref});
        run_crc();
        `CHK(crc_error, 1'b1)
        rd(tbx_pkg::OFF_CRCVAL, rv);
        `CHK(rv[15:0], cref)
        wr(tbx_pkg::OFF_CRCREF, {16'h0000, cref});
        run_crc();
        `CHK(crc_error, 1'b0)
        rd(tbx_pkg::OFF_STATUS, rv);
        `CHK(rv[1:0], 2'h2)
        $display("Test checksum done");
        finish_test();
    end
endmodule
